// ===== src/pec_top.sv
// Purpose: Edge-change interrupt controller for general-purpose port pins.
// Assumes: APB slave, 200 MHz mclk_i, asynchronous active-high reset.
// Notes: Flags clear on writing zero; a same-cycle edge keeps its flag set.
// Contract
// - Every pin of every port can raise the change interrupt.
// - Each pin has separate rising and falling edge detectors.
// - Rising detection works only while the pin's rise enable bit is one.
// - Falling detection works only while the pin's fall enable bit is one.
// - With both enables set, edges of either direction are flagged.
// - An enabled edge sets that pin's change flag bit.
// - Detection continues with interrupts disabled; only the request and the wake pulse are suppressed.
// - Summary flag is the OR of all pin change flags.
// - Software clears a pin flag by writing zero to it.
// - An edge during a clearing write leaves the flag set.
// - An enabled change wakes the device when the interrupt enable is set.
// - Edges during sleep are recorded in flags at the same clock edge as the wake pulse.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pec_top #(
    parameter int NUM_PORTS = pec_pkg::PEC_NUM_PORTS,
    parameter int PORT_W = pec_pkg::PEC_PORT_W
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [NUM_PORTS*PORT_W-1:0] pin_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pec_pkg::PEC_ADDR_W-1:0] paddr,
    input wire logic [pec_pkg::PEC_DATA_W-1:0] pwdata,
    output logic [pec_pkg::PEC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic change_summary_flag_o,
    output logic irq_o,
    output logic wake_o
);
    localparam int NPIN = NUM_PORTS * PORT_W;
    // Low address bits select the register inside one port block.
    localparam int OFS_W = $clog2(pec_pkg::PEC_PORT_STRIDE);

    pec_pkg::pec_apb_req_t req;
    pec_pkg::pec_ctrl_t ctrl;
    pec_pkg::pec_ctrl_t next_ctrl;
    logic [NPIN-1:0] rise_edge_enable_reg;
    logic [NPIN-1:0] next_rise;
    logic [NPIN-1:0] fall_edge_enable_reg;
    logic [NPIN-1:0] next_fall;
    logic [NPIN-1:0] pin_change_flag_reg;
    logic [NPIN-1:0] next_flag;
    logic [NPIN-1:0] edge_hit;
    logic [pec_pkg::PEC_STAT_W-1:0] stat;
    logic [pec_pkg::PEC_STAT_W-1:0] next_stat;
    logic [pec_pkg::PEC_STAT_W-1:0] mask;
    logic [pec_pkg::PEC_STAT_W-1:0] next_mask;
    logic [pec_pkg::PEC_DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_summary;
    logic next_irq;
    logic next_wake;
    logic wr_fire;
    logic rd_fire;
    logic any_edge;
    logic wake_event;

    assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    // Access is taken in the first access-phase cycle; pready pulses in the cycle after it.
    assign wr_fire = psel & penable & ~pready & req.pwrite;
    assign rd_fire = psel & penable & ~pready & ~req.pwrite;

    // Port index for an address inside the port blocks, or NUM_PORTS if none.
    function automatic int port_of(input logic [pec_pkg::PEC_ADDR_W-1:0] a);
        int p;
        p = NUM_PORTS;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (a[pec_pkg::PEC_ADDR_W-1:OFS_W] ==
                    (pec_pkg::PEC_PORT_STRIDE[pec_pkg::PEC_ADDR_W-1:OFS_W] *
                    (pec_pkg::PEC_ADDR_W-OFS_W)'(i))) begin
                p = i;
            end
        end
        return p;
    endfunction

    function automatic logic [pec_pkg::PEC_ADDR_W-1:0] ofs_of(
            input logic [pec_pkg::PEC_ADDR_W-1:0] a);
        return {{(pec_pkg::PEC_ADDR_W-OFS_W){1'b0}}, a[OFS_W-1:0]};
    endfunction

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            pec_edge_det #(
                .WIDTH(PORT_W)
            ) u_det (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .clk_en_i(clk_en_i),
                .pin_i(pin_i[gp*PORT_W +: PORT_W]),
                .rise_en_i(rise_edge_enable_reg[gp*PORT_W +: PORT_W]),
                .fall_en_i(fall_edge_enable_reg[gp*PORT_W +: PORT_W]),
                .edge_o(edge_hit[gp*PORT_W +: PORT_W])
            );
        end
    endgenerate

    assign any_edge = |edge_hit;
    assign wake_event = any_edge & ctrl.irq_enable & ctrl.sleep;

    always_comb begin
        int p;
        logic [pec_pkg::PEC_ADDR_W-1:0] o;
        p = port_of(req.paddr);
        o = ofs_of(req.paddr);
        next_ctrl = ctrl;
        next_rise = rise_edge_enable_reg;
        next_fall = fall_edge_enable_reg;
        next_flag = pin_change_flag_reg;
        next_mask = mask;
        next_stat = stat;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (wr_fire | rd_fire) begin
            next_pready = 1'b1;
            next_prdata = pec_pkg::PEC_RESET_WORD;
        end
        if (wr_fire) begin
            if (p < NUM_PORTS && o == pec_pkg::PEC_OFS_RISE) begin
                next_rise[p*PORT_W +: PORT_W] = req.pwdata[PORT_W-1:0];
            end else if (p < NUM_PORTS && o == pec_pkg::PEC_OFS_FALL) begin
                next_fall[p*PORT_W +: PORT_W] = req.pwdata[PORT_W-1:0];
            end else if (p < NUM_PORTS && o == pec_pkg::PEC_OFS_FLAG) begin
                // Writing zero clears; writing one leaves a flag as it was.
                next_flag[p*PORT_W +: PORT_W] = pin_change_flag_reg[p*PORT_W +: PORT_W]
                    & req.pwdata[PORT_W-1:0];
            end else if (req.paddr == pec_pkg::PEC_ADDR_CTRL) begin
                next_ctrl.irq_enable = req.pwdata[pec_pkg::PEC_CTRL_IRQ_EN_BIT];
                next_ctrl.sleep = req.pwdata[pec_pkg::PEC_CTRL_SLEEP_BIT];
            end else if (req.paddr == pec_pkg::PEC_ADDR_MASK) begin
                next_mask = req.pwdata[pec_pkg::PEC_STAT_W-1:0];
            end else if (req.paddr != pec_pkg::PEC_ADDR_STAT) begin
                next_pslverr = 1'b1;
            end
        end
        if (rd_fire) begin
            if (p < NUM_PORTS && o == pec_pkg::PEC_OFS_RISE) begin
                next_prdata[PORT_W-1:0] = rise_edge_enable_reg[p*PORT_W +: PORT_W];
            end else if (p < NUM_PORTS && o == pec_pkg::PEC_OFS_FALL) begin
                next_prdata[PORT_W-1:0] = fall_edge_enable_reg[p*PORT_W +: PORT_W];
            end else if (p < NUM_PORTS && o == pec_pkg::PEC_OFS_FLAG) begin
                next_prdata[PORT_W-1:0] = pin_change_flag_reg[p*PORT_W +: PORT_W];
            end else if (req.paddr == pec_pkg::PEC_ADDR_CTRL) begin
                next_prdata[pec_pkg::PEC_CTRL_IRQ_EN_BIT] = ctrl.irq_enable;
                next_prdata[pec_pkg::PEC_CTRL_SLEEP_BIT] = ctrl.sleep;
            end else if (req.paddr == pec_pkg::PEC_ADDR_STAT) begin
                next_prdata[pec_pkg::PEC_STAT_W-1:0] = stat;
                next_stat = '0;
            end else if (req.paddr == pec_pkg::PEC_ADDR_MASK) begin
                next_prdata[pec_pkg::PEC_STAT_W-1:0] = mask;
            end else begin
                next_pslverr = 1'b1;
            end
        end
        // Edges win over any clear in the same cycle, regardless of irq enable.
        next_flag = next_flag | edge_hit;
        if (any_edge) begin
            next_stat[pec_pkg::PEC_STAT_EVENT_BIT] = 1'b1;
        end
        if (wake_event) begin
            next_stat[pec_pkg::PEC_STAT_WAKE_BIT] = 1'b1;
            next_ctrl.sleep = 1'b0;
        end
        next_summary = |next_flag;
        next_irq = ctrl.irq_enable & (|(next_stat & mask));
        next_wake = wake_event;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= '0;
            rise_edge_enable_reg <= '0;
            fall_edge_enable_reg <= '0;
            pin_change_flag_reg <= '0;
            stat <= '0;
            mask <= '0;
            prdata <= pec_pkg::PEC_RESET_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
            change_summary_flag_o <= 1'b0;
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else if (clk_en_i) begin
            ctrl <= next_ctrl;
            rise_edge_enable_reg <= next_rise;
            fall_edge_enable_reg <= next_fall;
            pin_change_flag_reg <= next_flag;
            stat <= next_stat;
            mask <= next_mask;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            change_summary_flag_o <= next_summary;
            irq_o <= next_irq;
            wake_o <= next_wake;
        end
    end

    // Checks. Pin 0 stands for every pin, since all pins share one generate body.
    // Port 0 has base address zero, so its flag register sits at the bare offset.
    // Properties that clk_en_i could freeze name it in the antecedent.
    sequence s_clear_write;
        clk_en_i && wr_fire && req.paddr == pec_pkg::PEC_OFS_FLAG;
    endsequence

    sequence s_wake_hit;
        clk_en_i && wake_event;
    endsequence

    sequence s_edge_seen(int k);
        clk_en_i && edge_hit[k];
    endsequence

    a_flag_sets: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_edge_seen(0) |=> pin_change_flag_reg[0])
        else $error("Edge did not set pin flag.");

    a_summary_or: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        change_summary_flag_o == (|pin_change_flag_reg))
        else $error("Summary flag differs from OR of pin flags.");

    a_clear_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_clear_write ##0 (!req.pwdata[0] && !edge_hit[0]) |=> !pin_change_flag_reg[0])
        else $error("Write of zero did not clear flag.");

    a_irq_gated: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && !ctrl.irq_enable |=> !irq_o)
        else $error("Interrupt raised while disabled.");

    a_rise_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !rise_edge_enable_reg[0] && !fall_edge_enable_reg[0] |-> !edge_hit[0])
        else $error("Edge detected on a disabled pin.");

    a_wake_pulse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && wake_event |=> wake_o && !ctrl.sleep)
        else $error("Enabled edge in sleep did not wake.");

    a_wake_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wake_o |-> change_summary_flag_o)
        else $error("Woke without a recorded flag.");

    a_no_wake_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && !ctrl.irq_enable |=> !wake_o)
        else $error("Woke with interrupt enable clear.");

    a_race_wins: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_clear_write ##0 edge_hit[0] |=> pin_change_flag_reg[0])
        else $error("Clearing write lost a same-cycle edge.");

    a_flag_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && !edge_hit[0] && !(wr_fire && req.paddr == pec_pkg::PEC_OFS_FLAG)
        |=> pin_change_flag_reg[0] == $past(pin_change_flag_reg[0]))
        else $error("Pin flag changed without an edge or a write.");

    a_flag_no_irq: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && !ctrl.irq_enable && edge_hit[0] |=> pin_change_flag_reg[0])
        else $error("Edge lost while interrupts were disabled.");

    a_stat_event: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && any_edge |=> stat[pec_pkg::PEC_STAT_EVENT_BIT])
        else $error("Edge did not set the event status bit.");

    a_irq_level: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && ctrl.irq_enable && (|(stat & mask)) && !rd_fire |=> irq_o)
        else $error("Unmasked status with interrupts enabled gave no request.");

    a_summary_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && !(|pin_change_flag_reg) && !any_edge |=> !change_summary_flag_o)
        else $error("Summary flag set with no pin flag.");

    a_sleep_stay: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && ctrl.sleep && !ctrl.irq_enable && !wr_fire |=> ctrl.sleep)
        else $error("Left sleep with interrupt enable clear.");

    a_wake_sleep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && !ctrl.sleep |=> !wake_o)
        else $error("Wake pulse while not asleep.");

    a_wake_once: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_wake_hit ##1 clk_en_i |=> !wake_o)
        else $error("Wake pulse lasted more than one cycle.");

    a_pready_pulse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clk_en_i && pready |=> !pready)
        else $error("Ready held for more than one cycle.");

    a_frozen: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !clk_en_i |=> $stable(pin_change_flag_reg) && $stable(irq_o))
        else $error("State changed while the clock enable was low.");
endmodule

// ===== pkg/pec_pkg.sv
// Purpose: Shared constants and types for the pin edge-change interrupt block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Ports are up to 8 pins wide; registers use the low bits.
package pec_pkg;
    localparam int PEC_NUM_PORTS = 3;
    localparam int PEC_PORT_W = 8;
    localparam int PEC_ADDR_W = 8;
    localparam int PEC_DATA_W = 32;
    // Each port owns a four-word block with three registers: rise enable, fall enable, flags.
    localparam logic [PEC_ADDR_W-1:0] PEC_PORT_STRIDE = 8'h10;
    localparam logic [PEC_ADDR_W-1:0] PEC_OFS_RISE = 8'h00;
    localparam logic [PEC_ADDR_W-1:0] PEC_OFS_FALL = 8'h04;
    localparam logic [PEC_ADDR_W-1:0] PEC_OFS_FLAG = 8'h08;
    // Module-wide registers above the port blocks.
    localparam logic [PEC_ADDR_W-1:0] PEC_ADDR_CTRL = 8'h80;
    localparam logic [PEC_ADDR_W-1:0] PEC_ADDR_STAT = 8'h84;
    localparam logic [PEC_ADDR_W-1:0] PEC_ADDR_MASK = 8'h88;
    localparam int PEC_CTRL_IRQ_EN_BIT = 0;
    localparam int PEC_CTRL_SLEEP_BIT = 1;
    localparam int PEC_STAT_EVENT_BIT = 0;
    localparam int PEC_STAT_WAKE_BIT = 1;
    localparam int PEC_STAT_W = 2;
    localparam logic [PEC_DATA_W-1:0] PEC_RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [PEC_ADDR_W-1:0] paddr;
        logic pwrite;
        logic [PEC_DATA_W-1:0] pwdata;
    } pec_apb_req_t;

    typedef struct packed {
        logic irq_enable;
        logic sleep;
    } pec_ctrl_t;
endpackage

// ===== src/pec_edge_det.sv
// Purpose: One port of pin change detectors with synchroniser and edge logic.
// Assumes: Pins are asynchronous to mclk_i.
// Notes: Outputs are one-cycle pulses for each enabled edge.
`timescale 1ns/1ps
module pec_edge_det #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] rise_en_i,
    input wire logic [WIDTH-1:0] fall_en_i,
    output logic [WIDTH-1:0] edge_o
);
    logic [WIDTH-1:0] sync_a;
    logic [WIDTH-1:0] sync_b;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
            prev <= '0;
        end else if (clk_en_i) begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            // Two independent detectors per pin, each gated by its own enable.
            always_comb begin
                edge_o[g] = (rise_en_i[g] & sync_b[g] & ~prev[g])
                    | (fall_en_i[g] & ~sync_b[g] & prev[g]);
            end
        end
    endgenerate
endmodule

// ===== tb/pec_pin_model.sv
// Purpose: Drives the general-purpose port pins seen by the change detectors.
// Assumes: The bench asks for a new pin pattern with a one-cycle load strobe.
// Notes: Pins idle low after reset and change only just after a rising edge.
`timescale 1ns/1ps
module pec_pin_model #(
    parameter int W = 24
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    output logic [W-1:0] pin_o
);
    logic [W-1:0] next_pin;
    always_comb begin
        next_pin = load_i ? value_i : pin_o;
    end
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_o <= '0;
        end else begin
            pin_o <= next_pin;
        end
    end
endmodule

// ===== tb/pin_edge_change_interrupt_tb.sv
// Purpose: Self-checking bench for the pin edge-change interrupt block.
// Assumes: APB answers with pready one cycle after the access phase starts.
// Notes: Expected register reads are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module pin_edge_change_interrupt_tb;
    localparam int NP = pec_pkg::PEC_NUM_PORTS;
    localparam int PW = NP * pec_pkg::PEC_PORT_W;
    typedef struct packed {logic rd; logic err; logic [31:0] data;} pec_note_t;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pin_load = 1'b0;
    logic [PW-1:0] pin_val = '0;
    logic [PW-1:0] pin_i;
    logic [31:0] prdata;
    logic pready, pslverr, change_summary_flag_o, irq_o, wake_o;
    pec_note_t notes[$];
    pec_note_t got;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int wake_cnt = 0;
    int wake_exp = 0;
    logic [PW-1:0] ren = '0, fen = '0, flag_exp = '0, cur = '0, seen;
    logic [31:0] stat_exp = 32'h0000_0000;
    logic sleep_exp = 1'b0;
    int unsigned seed;

    always #2.5 mclk_i = ~mclk_i;

    pec_pin_model #(.W(PW)) i_pins (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .load_i(pin_load), .value_i(pin_val), .pin_o(pin_i));
    pec_top i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .pin_i(pin_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .change_summary_flag_o(change_summary_flag_o), .irq_o(irq_o), .wake_o(wake_o));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    function automatic logic [7:0] ra(input int p, input logic [7:0] o);
        return 8'(p) * pec_pkg::PEC_PORT_STRIDE + o;
    endfunction

    // For a read, d is the expected data; the write data lines carry noise.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic er = 1'b0);
        notes.push_back('{~w, er, d});
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : $urandom;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(negedge mclk_i);
        while (pready !== 1'b1) @(negedge mclk_i);
        @(posedge mclk_i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic drive_pins(input logic [PW-1:0] v, input int settle);
        logic [PW-1:0] hit;
        hit = (ren & v & ~cur) | (fen & ~v & cur);
        flag_exp |= hit;
        if (hit != '0) begin
            stat_exp[pec_pkg::PEC_STAT_EVENT_BIT] = 1'b1;
            if (sleep_exp) begin
                stat_exp[pec_pkg::PEC_STAT_WAKE_BIT] = 1'b1;
                wake_exp++;
                sleep_exp = 1'b0;
            end
        end
        cur = v;
        @(posedge mclk_i);
        pin_load <= 1'b1;
        pin_val <= v;
        @(posedge mclk_i);
        pin_load <= 1'b0;
        repeat (settle) @(posedge mclk_i);
    endtask

    task automatic set_en();
        for (int p = 0; p < NP; p++) begin
            apb(1'b1, ra(p, pec_pkg::PEC_OFS_RISE), 32'(ren[p*8 +: 8]));
            apb(1'b1, ra(p, pec_pkg::PEC_OFS_FALL), 32'(fen[p*8 +: 8]));
        end
    endtask

    task automatic read_flags();
        for (int p = 0; p < NP; p++) begin
            apb(1'b0, ra(p, pec_pkg::PEC_OFS_FLAG), 32'(flag_exp[p*8 +: 8]));
        end
    endtask

    always @(negedge mclk_i) begin
        if (psel && penable && pready === 1'b1) begin
            got = notes.pop_front();
            chk(32'(pslverr), 32'(got.err));
            if (got.rd) chk(prdata, got.data);
        end
        if (wake_o === 1'b1) wake_cnt++;
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        seed = $urandom(58);
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        for (int p = 0; p < NP; p++) begin
            for (int k = 0; k < 3; k++) apb(1'b0, ra(p, 8'(4 * k)), pec_pkg::PEC_RESET_WORD);
        end
        apb(1'b0, pec_pkg::PEC_ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, pec_pkg::PEC_ADDR_MASK, 32'h0000_0000);
        apb(1'b0, 8'h0C, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, 1'b1);
        $display("test reset and decode done");
        for (int r = 0; r < 6; r++) begin
            ren = (r == 0) ? '1 : PW'($urandom);
            fen = (r == 0) ? '1 : PW'($urandom);
            set_en();
            drive_pins(PW'($urandom), 8);
            read_flags();
            @(negedge mclk_i);
            chk(32'(change_summary_flag_o), 32'(|flag_exp));
            chk(32'(irq_o), 32'h0000_0000);
        end
        $display("test edge detection done");
        for (int s = 0; s < 2; s++) begin
            seen = (s == 0) ? flag_exp & PW'($urandom) : flag_exp;
            for (int p = 0; p < NP; p++) begin
                apb(1'b1, ra(p, pec_pkg::PEC_OFS_FLAG), 32'(~seen[p*8 +: 8]));
            end
            flag_exp &= ~seen;
            read_flags();
            @(negedge mclk_i);
            chk(32'(change_summary_flag_o), 32'(|flag_exp));
        end
        $display("test flag clear done");
        ren = PW'(1);
        fen = '0;
        set_en();
        drive_pins('0, 8);
        // The edge reaches the flag at the very edge that takes the clearing write.
        drive_pins(PW'(1), 0);
        apb(1'b1, ra(0, pec_pkg::PEC_OFS_FLAG), 32'h0000_0000);
        read_flags();
        $display("test clear race done");
        apb(1'b0, pec_pkg::PEC_ADDR_STAT, stat_exp);
        stat_exp = '0;
        apb(1'b1, pec_pkg::PEC_ADDR_MASK, 32'h0000_0000);
        apb(1'b1, pec_pkg::PEC_ADDR_CTRL, 32'h0000_0001);
        drive_pins('0, 8);
        drive_pins(PW'(1), 8);
        @(negedge mclk_i);
        chk(32'(irq_o), 32'h0000_0000);
        apb(1'b1, pec_pkg::PEC_ADDR_MASK, 32'h0000_0001);
        repeat (3) @(negedge mclk_i);
        chk(32'(irq_o), 32'h0000_0001);
        apb(1'b0, pec_pkg::PEC_ADDR_STAT, stat_exp);
        stat_exp = '0;
        repeat (3) @(negedge mclk_i);
        chk(32'(irq_o), 32'h0000_0000);
        $display("test interrupt done");
        apb(1'b1, pec_pkg::PEC_ADDR_CTRL, 32'h0000_0003);
        sleep_exp = 1'b1;
        drive_pins('0, 8);
        drive_pins(PW'(1), 8);
        @(negedge mclk_i);
        chk(32'(wake_cnt), 32'(wake_exp));
        chk(32'(irq_o), 32'h0000_0001);
        apb(1'b0, pec_pkg::PEC_ADDR_CTRL, 32'h0000_0001);
        read_flags();
        apb(1'b0, pec_pkg::PEC_ADDR_STAT, stat_exp);
        $display("test sleep wake done");
        apb(1'b1, ra(0, pec_pkg::PEC_OFS_FLAG), 32'h0000_0000);
        flag_exp = '0;
        ren = PW'(3);
        set_en();
        // A pin edge while the clock enable is low must wait until it rises again.
        @(posedge mclk_i);
        clk_en_i <= 1'b0;
        drive_pins(PW'(3), 8);
        @(negedge mclk_i);
        chk(32'(change_summary_flag_o), 32'h0000_0000);
        @(posedge mclk_i);
        clk_en_i <= 1'b1;
        repeat (8) @(negedge mclk_i);
        chk(32'(change_summary_flag_o), 32'h0000_0001);
        read_flags();
        $display("test clock enable done");
        test_done();
    end
endmodule
